// ### shared/hsb_pkg.sv
// hsb_pkg: constants and types for the hot-swap bus buffer control
// assumes a 20 MHz core clock; every time below becomes cycles of that clock
package hsb_pkg;
    // core clock
    localparam int CLK_PERIOD_NS = 50;
    // stuck-low timeout, least time, rounded up
    localparam int STUCK_TIME_US = 30000;
    localparam int STUCK_CYCLES = (STUCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STUCK_W = 20;
    // bus idle time, typical figure, rounded up
    localparam int IDLE_TIME_US = 95;
    localparam int IDLE_CYCLES = (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_W = 11;
    // recovery clock half period, longest time, rounded down
    localparam int PULSE_HALF_NS = 5000;
    localparam int PULSE_HALF_CYCLES = PULSE_HALF_NS / CLK_PERIOD_NS;
    localparam int PHASE_W = 7;
    // recovery pulse budget
    localparam int PULSE_MAX = 16;
    localparam int PULSE_W = 5;
    // synchroniser bit positions
    localparam int SYN_BP_DATA = 0;
    localparam int SYN_BP_CLK = 1;
    localparam int SYN_CARD_DATA = 2;
    localparam int SYN_CARD_CLK = 3;
    localparam int SYN_ENABLE = 4;
    localparam int SYN_ACC_N = 5;
    localparam int SYN_W = 6;
    // reset values
    localparam logic [SYN_W-1:0] SYN_RST = 6'h3F;

    typedef enum logic [1:0] {ST_WAIT, ST_CONN, ST_RECOVER} hsb_state_t;
endpackage : hsb_pkg

// ### rtl/hsb_ctrl.sv
// hsb_ctrl: connection, stuck-bus and recovery control of a hot-swap two-wire bus buffer
// assumes open-drain lines resolved outside; all pins arrive asynchronous to clk
// Contract
// [R01] card data or clock low for 30 ms opens both lines
// [R02] stuck disconnect pulls the active-low fault output low
// [R03] after stuck disconnect drive at most 16 pulses on card clock
// [R04] reconnect automatically once the stuck bus is free
// [R05] with enable high, connect only after stop condition or 95 us idle bus
// [R06] enable low disconnects data and clock between the two segments
// [R07] open-drain ready output shows whether the segments are connected
// [R08] accelerator input low turns rise-time boost on, high turns it off
// [R09] while connected, lows on each line are mirrored in both directions
// [R10] stuck timer restarts while card lines high; fault released at reconnection
// [R11] all intervals are counted cycles of the free-running core clock; the counters advance only in cycles with clk_en high
`timescale 1ns/100ps
`default_nettype none
module hsb_ctrl #(
    parameter int STUCK_LIMIT = hsb_pkg::STUCK_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic backplane_data_line_in,
    output logic backplane_data_line_out,
    output logic backplane_data_line_oe_n,
    input wire logic backplane_clock_line_in,
    output logic backplane_clock_line_out,
    output logic backplane_clock_line_oe_n,
    input wire logic card_data_line_in,
    output logic card_data_line_out,
    output logic card_data_line_oe_n,
    input wire logic card_clock_line_in,
    output logic card_clock_line_out,
    output logic card_clock_line_oe_n,
    input wire logic enable,
    input wire logic acc_n,
    output logic ready_out,
    output logic ready_oe_n,
    output logic fault_n_out,
    output logic fault_n_oe_n,
    output logic accel_on
);
    import hsb_pkg::*;

    logic [SYN_W-1:0] sync1_ff, sync2_ff;
    hsb_state_t state_ff, nxt_state;
    logic [STUCK_W-1:0] stuck_cnt_ff, nxt_stuck_cnt;
    logic [IDLE_W-1:0] idle_cnt_ff, nxt_idle_cnt;
    logic [PULSE_W-1:0] pulse_cnt_ff, nxt_pulse_cnt;
    logic [PHASE_W-1:0] phase_cnt_ff, nxt_phase_cnt;
    logic rec_low_ff, nxt_rec_low;
    logic drv_card_data_ff, nxt_drv_card_data;
    logic drv_card_clk_ff, nxt_drv_card_clk;
    logic drv_bp_data_ff, nxt_drv_bp_data;
    logic drv_bp_clk_ff, nxt_drv_bp_clk;
    logic fault_ff, nxt_fault;
    logic ready_ff, nxt_ready;
    logic accel_ff, nxt_accel;
    logic bp_data_d_ff;
    logic [3:0] own1_ff, nxt_own1, own2_ff, nxt_own2, echo_mask;
    logic s_bp_data, s_bp_clk, s_card_data, s_card_clk, s_en, s_acc_n;
    logic card_low, bus_high, stuck_hit, idle_hit, stop_seen, phase_end;

    assign s_bp_data = sync2_ff[SYN_BP_DATA];
    assign s_bp_clk = sync2_ff[SYN_BP_CLK];
    assign s_card_data = sync2_ff[SYN_CARD_DATA];
    assign s_card_clk = sync2_ff[SYN_CARD_CLK];
    assign s_en = sync2_ff[SYN_ENABLE];
    assign s_acc_n = sync2_ff[SYN_ACC_N];

    // two-flop synchroniser for every bus, enable and accelerator pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= SYN_RST;
            sync2_ff <= SYN_RST;
            bp_data_d_ff <= 1'b1;
        end else if (clk_en) begin
            sync1_ff <= {acc_n, enable, card_clock_line_in, card_data_line_in,
                         backplane_clock_line_in, backplane_data_line_in};
            sync2_ff <= sync1_ff;
            bp_data_d_ff <= s_bp_data;
        end
    end

    always_comb begin
        card_low = !s_card_data || !s_card_clk;
        bus_high = s_bp_data && s_bp_clk && s_card_data && s_card_clk;
        stuck_hit = card_low && (state_ff != ST_RECOVER) &&
                    (stuck_cnt_ff == STUCK_W'(STUCK_LIMIT - 1)); // R01 R11
        idle_hit = bus_high && (idle_cnt_ff == IDLE_W'(IDLE_CYCLES - 1)); // R05 R11
        stop_seen = s_bp_clk && s_bp_data && !bp_data_d_ff; // R05
        phase_end = (phase_cnt_ff == PHASE_W'(PULSE_HALF_CYCLES - 1)); // R11
        // own drives, still visible through the synchroniser for two cycles
        echo_mask = {drv_card_clk_ff, drv_card_data_ff, drv_bp_clk_ff, drv_bp_data_ff} | own1_ff | own2_ff; // R09
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_stuck_cnt = stuck_cnt_ff;
        nxt_idle_cnt = idle_cnt_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_phase_cnt = phase_cnt_ff;
        nxt_rec_low = rec_low_ff;
        nxt_fault = fault_ff;
        // stuck-low timer
        if (!card_low || state_ff == ST_RECOVER) begin
            nxt_stuck_cnt = '0; // R10
        end else if (!stuck_hit) begin
            nxt_stuck_cnt = stuck_cnt_ff + 1'b1; // R11
        end
        // idle timer
        if (!bus_high) begin
            nxt_idle_cnt = '0;
        end else if (!idle_hit) begin
            nxt_idle_cnt = idle_cnt_ff + 1'b1;
        end
        case (state_ff)
            ST_WAIT: begin
                if (stuck_hit) begin
                    nxt_state = ST_RECOVER; // R01
                    nxt_fault = 1'b1; // R02
                    nxt_pulse_cnt = '0;
                    nxt_phase_cnt = '0;
                    nxt_rec_low = 1'b0;
                end else if (s_en && (idle_hit || stop_seen)) begin
                    nxt_state = ST_CONN; // R05 R04
                    nxt_fault = 1'b0; // R10
                end
            end
            ST_CONN: begin
                if (stuck_hit) begin
                    nxt_state = ST_RECOVER; // R01
                    nxt_fault = 1'b1; // R02
                    nxt_pulse_cnt = '0;
                    nxt_phase_cnt = '0;
                    nxt_rec_low = 1'b0;
                end else if (!s_en) begin
                    nxt_state = ST_WAIT; // R06
                end
            end
            ST_RECOVER: begin
                if (!rec_low_ff && !card_low) begin
                    nxt_state = ST_WAIT; // R04
                    nxt_phase_cnt = '0;
                end else if (phase_end) begin
                    nxt_phase_cnt = '0;
                    if (rec_low_ff) begin
                        nxt_rec_low = 1'b0;
                        nxt_pulse_cnt = pulse_cnt_ff + 1'b1;
                    end else if (pulse_cnt_ff < PULSE_W'(PULSE_MAX)) begin
                        nxt_rec_low = 1'b1; // R03
                    end
                end else begin
                    nxt_phase_cnt = phase_cnt_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_WAIT;
            end
        endcase
        nxt_own1 = {drv_card_clk_ff, drv_card_data_ff, drv_bp_clk_ff, drv_bp_data_ff};
        nxt_own2 = own1_ff;
        // mirroring; own lows masked until released, else the two sides ping-pong
        nxt_drv_card_data = (nxt_state == ST_CONN) && !s_bp_data && !echo_mask[SYN_BP_DATA]; // R09
        nxt_drv_bp_data = (nxt_state == ST_CONN) && !s_card_data && !echo_mask[SYN_CARD_DATA]; // R09
        nxt_drv_bp_clk = (nxt_state == ST_CONN) && !s_card_clk && !echo_mask[SYN_CARD_CLK]; // R09
        nxt_drv_card_clk = ((nxt_state == ST_CONN) && !s_bp_clk && !echo_mask[SYN_BP_CLK]) ||
                           ((nxt_state == ST_RECOVER) && nxt_rec_low); // R09 R03
        nxt_ready = (nxt_state == ST_CONN); // R07
        nxt_accel = !s_acc_n; // R08
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_WAIT;
            stuck_cnt_ff <= '0;
            idle_cnt_ff <= '0;
            pulse_cnt_ff <= '0;
            phase_cnt_ff <= '0;
            rec_low_ff <= 1'b0;
            drv_card_data_ff <= 1'b0;
            drv_card_clk_ff <= 1'b0;
            drv_bp_data_ff <= 1'b0;
            drv_bp_clk_ff <= 1'b0;
            fault_ff <= 1'b0;
            ready_ff <= 1'b0;
            accel_ff <= 1'b0;
            own1_ff <= '0;
            own2_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            stuck_cnt_ff <= nxt_stuck_cnt;
            idle_cnt_ff <= nxt_idle_cnt;
            pulse_cnt_ff <= nxt_pulse_cnt;
            phase_cnt_ff <= nxt_phase_cnt;
            rec_low_ff <= nxt_rec_low;
            drv_card_data_ff <= nxt_drv_card_data;
            drv_card_clk_ff <= nxt_drv_card_clk;
            drv_bp_data_ff <= nxt_drv_bp_data;
            drv_bp_clk_ff <= nxt_drv_bp_clk;
            fault_ff <= nxt_fault;
            ready_ff <= nxt_ready;
            accel_ff <= nxt_accel;
            own1_ff <= nxt_own1;
            own2_ff <= nxt_own2;
        end
    end

    // open-drain pins only ever pull low
    assign backplane_data_line_out = 1'b0;
    assign backplane_clock_line_out = 1'b0;
    assign card_data_line_out = 1'b0;
    assign card_clock_line_out = 1'b0;
    assign ready_out = 1'b0;
    assign fault_n_out = 1'b0;
    assign backplane_data_line_oe_n = !drv_bp_data_ff;
    assign backplane_clock_line_oe_n = !drv_bp_clk_ff;
    assign card_data_line_oe_n = !drv_card_data_ff;
    assign card_clock_line_oe_n = !drv_card_clk_ff;
    assign ready_oe_n = ready_ff; // R07
    assign fault_n_oe_n = !fault_ff; // R02
    assign accel_on = accel_ff; // R08

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n || !clk_en);

    sequence s_stuck_trip;
        stuck_hit;
    endsequence
    sequence s_freed;
        (state_ff == ST_RECOVER) && !rec_low_ff && !card_low;
    endsequence

    property p_stuck_open;
        s_stuck_trip |=> (state_ff == ST_RECOVER) && backplane_data_line_oe_n && backplane_clock_line_oe_n
                         && card_data_line_oe_n && card_clock_line_oe_n;
    endproperty
    a_stuck_open: assert property (p_stuck_open) else $error("stuck bus did not open"); // R01
    property p_fault_low;
        s_stuck_trip |=> !fault_n_oe_n;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault not pulled low"); // R02
    property p_pulse_budget;
        (pulse_cnt_ff == PULSE_W'(PULSE_MAX)) |-> !card_clock_line_oe_n == 1'b0 || state_ff != ST_RECOVER;
    endproperty
    a_pulse_budget: assert property (p_pulse_budget) else $error("more than 16 recovery pulses"); // R03
    property p_pulse_width;
        $rose(rec_low_ff) |-> rec_low_ff [*8] ##0 (state_ff == ST_RECOVER);
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("recovery pulse too short"); // R11
    property p_auto_reconnect;
        s_freed |=> (state_ff == ST_WAIT) && fault_ff;
    endproperty
    a_auto_reconnect: assert property (p_auto_reconnect) else $error("freed bus not released"); // R04
    property p_idle_connect;
        (state_ff == ST_WAIT) && s_en && idle_hit && !stuck_hit |=> (state_ff == ST_CONN) && !fault_ff;
    endproperty
    a_idle_connect: assert property (p_idle_connect) else $error("idle bus did not connect"); // R05 R10
    property p_no_early_connect;
        (state_ff == ST_WAIT) && !idle_hit && !stop_seen |=> state_ff != ST_CONN;
    endproperty
    a_no_early_connect: assert property (p_no_early_connect) else $error("connected without stop or idle"); // R05
    property p_enable_low;
        !s_en |=> (state_ff != ST_CONN) && card_data_line_oe_n && backplane_data_line_oe_n
                  && backplane_clock_line_oe_n && (card_clock_line_oe_n || state_ff == ST_RECOVER);
    endproperty
    a_enable_low: assert property (p_enable_low) else $error("enable low left segments joined"); // R06
    property p_ready;
        (ready_oe_n == (state_ff == ST_CONN)) &&
        (ready_oe_n || (card_data_line_oe_n && backplane_data_line_oe_n && backplane_clock_line_oe_n));
    endproperty
    a_ready: assert property (p_ready) else $error("ready disagrees with connection"); // R07
    property p_accel;
        s_acc_n |=> !accel_on;
    endproperty
    a_accel: assert property (p_accel) else $error("accelerator on with input high"); // R08
    property p_mirror;
        (state_ff == ST_CONN) && !s_bp_data && !echo_mask[SYN_BP_DATA] |=>
            (state_ff != ST_CONN) || !card_data_line_oe_n;
    endproperty
    a_mirror: assert property (p_mirror) else $error("backplane low not mirrored"); // R09
    property p_timer_restart;
        s_card_data && s_card_clk |=> stuck_cnt_ff == '0;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("stuck timer not restarted"); // R10
endmodule : hsb_ctrl
`default_nettype wire

// ### testbench/hsb_bus_model.sv
// hsb_bus_model: pulled-up backplane and card segments, plus a card slave that can hold data low
// assumes open-drain enables from the device, low = pulling the wire
`timescale 1ns/100ps
`default_nettype none
module hsb_bus_model (
    input wire logic bp_data_oe_n,
    input wire logic bp_clk_oe_n,
    input wire logic card_data_oe_n,
    input wire logic card_clk_oe_n,
    input wire logic [1:0] bp_pull,
    input wire logic [1:0] card_pull,
    input wire logic stuck_go,
    input wire logic [4:0] stuck_pulses,
    output logic bp_data,
    output logic bp_clk,
    output logic card_data,
    output logic card_clk
);
    logic held;
    int seen = 0;
    // slave holds data low while stuck_go is high until enough clocks arrive
    always @(negedge card_clk or negedge stuck_go) begin
        if (!stuck_go) begin
            seen = 0;
        end else if (seen < 31) begin
            seen = seen + 1;
        end
    end
    assign held = stuck_go && (seen < stuck_pulses);
    // pull-ups win when nobody pulls; pull bit 0 data, bit 1 clock
    assign bp_data = bp_data_oe_n & ~bp_pull[0];
    assign bp_clk = bp_clk_oe_n & ~bp_pull[1];
    assign card_data = card_data_oe_n & ~card_pull[0] & ~held;
    assign card_clk = card_clk_oe_n & ~card_pull[1];
endmodule : hsb_bus_model
`default_nettype wire

// ### testbench/hsb_ctrl_tb.sv
// hsb_ctrl_tb: directed scenarios for the bus buffer control
// assumes hsb_bus_model resolves the wires; short stuck limit for speed
`timescale 1ns/100ps
`default_nettype none
module hsb_ctrl_tb;
    import hsb_pkg::*;
    localparam int LIMIT = 50;
    logic clk, arst_n, clk_en, enable, acc_n, go;
    logic [1:0] bp_pull, card_pull;
    logic [4:0] npass;
    logic bpd, bpc, cd, cc, bpd_oe_n, bpc_oe_n, cd_oe_n, cc_oe_n, rdy_oe_n, flt_oe_n, accel_on;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int pulses = 0;

    hsb_ctrl #(.STUCK_LIMIT(LIMIT)) hsb_ctrl_inst (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .backplane_data_line_in(bpd), .backplane_data_line_out(), .backplane_data_line_oe_n(bpd_oe_n),
        .backplane_clock_line_in(bpc), .backplane_clock_line_out(), .backplane_clock_line_oe_n(bpc_oe_n),
        .card_data_line_in(cd), .card_data_line_out(), .card_data_line_oe_n(cd_oe_n),
        .card_clock_line_in(cc), .card_clock_line_out(), .card_clock_line_oe_n(cc_oe_n),
        .enable(enable), .acc_n(acc_n), .ready_out(), .ready_oe_n(rdy_oe_n),
        .fault_n_out(), .fault_n_oe_n(flt_oe_n), .accel_on(accel_on));
    hsb_bus_model hsb_bus_model_inst (.bp_data_oe_n(bpd_oe_n), .bp_clk_oe_n(bpc_oe_n),
        .card_data_oe_n(cd_oe_n), .card_clk_oe_n(cc_oe_n), .bp_pull(bp_pull), .card_pull(card_pull),
        .stuck_go(go), .stuck_pulses(npass), .bp_data(bpd), .bp_clk(bpc), .card_data(cd), .card_clk(cc));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // recovery pulses seen on the card clock
    always @(negedge cc_oe_n) pulses++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wait_ready(input logic v, input int lim);
        for (int i = 0; i < lim && rdy_oe_n !== v; i++) @(negedge clk);
    endtask : wait_ready
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic t_accel;
        acc_n = 1'b0;
        cyc(4);
        check("accel_on", accel_on, 1);
        acc_n = 1'b1;
        cyc(4);
        check("accel_on", accel_on, 0);
    endtask : t_accel
    task automatic t_idle;
        enable = 1'b1;
        cyc(1100);
        check("ready early", rdy_oe_n, 0);
        wait_ready(1'b1, 2500);
        check("ready idle", rdy_oe_n, 1);
    endtask : t_idle
    task automatic t_mirror;
        bp_pull = 2'h1;
        cyc(4);
        check("card data", cd, 0);
        bp_pull = 2'h0;
        cyc(4);
        check("card data", cd, 1);
        check("bp data echo", bpd, 1);
        card_pull = 2'h1;
        cyc(LIMIT - 10);
        check("bp data", bpd, 0);
        card_pull = 2'h0;
        cyc(4);
        card_pull = 2'h1;
        cyc(LIMIT - 10);
        check("fault", flt_oe_n, 1);
        card_pull = 2'h0;
        cyc(4);
        card_pull = 2'h2;
        cyc(4);
        check("bp clk", bpc, 0);
        card_pull = 2'h0;
        cyc(4);
        check("bp clk", bpc, 1);
        bp_pull = 2'h2;
        cyc(4);
        check("card clk", cc, 0);
        bp_pull = 2'h0;
        cyc(4);
        check("card clk", cc, 1);
    endtask : t_mirror
    task automatic t_enable_stop;
        enable = 1'b0;
        cyc(5);
        check("ready off", rdy_oe_n, 0);
        bp_pull = 2'h1;
        cyc(5);
        check("card data", cd, 1);
        enable = 1'b1;
        cyc(5);
        check("ready no stop", rdy_oe_n, 0);
        bp_pull = 2'h0;
        cyc(5);
        check("ready stop", rdy_oe_n, 1);
    endtask : t_enable_stop
    task automatic t_freeze;
        clk_en = 1'b0;
        bp_pull = 2'h1;
        cyc(6);
        check("card data frozen", cd, 1);
        check("ready frozen", rdy_oe_n, 1);
        bp_pull = 2'h0;
        clk_en = 1'b1;
        cyc(4);
        check("card data thawed", cd, 1);
    endtask : t_freeze
    task automatic t_stuck(input logic [4:0] n, input int exp_pulses);
        int base;
        npass = n;
        base = pulses;
        go = 1'b1;
        cyc(LIMIT);
        check("ready before trip", rdy_oe_n, 1);
        wait_ready(1'b0, 10);
        check("ready trip", rdy_oe_n, 0);
        check("fault trip", flt_oe_n, 0);
        check("bp data open", bpd, 1);
        check("bp clk open", bpc, 1);
        check("card clk open", cc, 1);
        cyc(16 * 200 + 400);
        check("pulses", pulses - base, exp_pulses);
        go = 1'b0;
        cyc(1);
        wait_ready(1'b1, 3600);
        check("ready back", rdy_oe_n, 1);
        check("fault off", flt_oe_n, 1);
    endtask : t_stuck

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        enable = 1'b0;
        acc_n = 1'b1;
        bp_pull = 2'h0;
        card_pull = 2'h0;
        go = 1'b0;
        npass = 5'h00;
        cyc(12);
        check("ready rst", rdy_oe_n, 0);
        check("fault rst", flt_oe_n, 1);
        arst_n = 1'b1;
        t_accel();
        t_idle();
        t_mirror();
        t_enable_stop();
        t_freeze();
        t_stuck(5'h03, 3);
        t_stuck(5'h14, 16);
        summarize();
    end
endmodule : hsb_ctrl_tb
`default_nettype wire
